/* File: error_log_vc_defines.svh */
/*
 * offsets, field positions, reset values and fixed read values of the
 * error log and channel capability register bank.
 * assumes byte addresses within the function's configuration space.
 */
`ifndef ERROR_LOG_VC_DEFINES_SVH
`define ERROR_LOG_VC_DEFINES_SVH

// Contract
// - keep a sticky read-only 5-bit index of the first uncorrectable error, reset zero
// - bit 5 reads one: end-to-end CRC generation is supported
// - generate end-to-end CRC only while sticky enable bit 6 is set, reset zero
// - bit 7 reads one: end-to-end CRC checking is supported
// - check end-to-end CRC only while sticky enable bit 8 is set, reset zero
// - capture four header doublewords into a sticky 128-bit log, first at 31:0
// - store each doubleword big-endian, first header byte in the top lane
// - channel capability header returns identifier 0002h in bits 15:0
// - channel capability header returns version 1h in bits 19:16
// - next capability pointer in bits 31:20 reads 20Ch
// - extended channel count upper bits reset zero, lowest bit from the strap
// - strap level or EEPROM auto-load may replace the default channel count
// - bits 6:4 give the low-priority group count, reset zero, EEPROM may override
// - reference clock field in bits 9:8 reads 00b, a 100 ns reference
// - arbitration table entry size field reads 10b, four-bit entries
// - arbitration capability reads 03h when count bit 0 is one, else 00h
// - table offset in bits 31:24 reads 03h when count bit 0 is one, else 00h
// - a masked correctable error is never captured into the header log

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_ADV_ERR_CAP_CONTROL      12'h118
`define OFS_ERROR_HEADER_LOG0        12'h11C
`define OFS_ERROR_HEADER_LOG1        12'h120
`define OFS_ERROR_HEADER_LOG2        12'h124
`define OFS_ERROR_HEADER_LOG3        12'h128
`define OFS_CHANNEL_EXT_CAP_HEADER   12'h140
`define OFS_PORT_CHANNEL_CAP_ONE     12'h144
`define OFS_PORT_CHANNEL_CAP_TWO     12'h148

// ----------------------------------------------------------------
// adv_error_cap_control fields
// ----------------------------------------------------------------
`define BIT_CRC_GEN_CAPABLE          5
`define BIT_CRC_GEN_ENABLE           6
`define BIT_CRC_CHK_CAPABLE          7
`define BIT_CRC_CHK_ENABLE           8
`define RST_FIRST_ERROR_PTR          5'h00
`define RST_CRC_GEN_ENABLE           1'h0
`define RST_CRC_CHK_ENABLE           1'h0
`define VAL_CRC_GEN_CAPABLE          1'h1
`define VAL_CRC_CHK_CAPABLE          1'h1

// ----------------------------------------------------------------
// channel capability values
// ----------------------------------------------------------------
`define VAL_EXT_CAP_ID               16'h0002
`define VAL_CAP_VERSION              4'h1
`define VAL_NEXT_CAP_OFFSET          12'h20C
`define RST_EXT_COUNT_HI             2'h0
`define RST_EXT_COUNT                3'h0
`define RST_LOW_PRIO_COUNT           3'h0
`define VAL_REF_CLOCK_100NS          2'h0
`define VAL_ENTRY_SIZE_4BIT          2'h2
`define VAL_ARB_CAP_ON               8'h03
`define VAL_ARB_CAP_OFF              8'h00
`define VAL_TABLE_OFS_ON             8'h03
`define VAL_TABLE_OFS_OFF            8'h00

`endif

/* File: error_log_vc_pkg.sv */
/*
 * types shared by the error log and channel capability bank.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package error_log_vc_pkg;

	typedef logic [11:0]  cfg_addr_t;
	typedef logic [31:0]  cfg_word_t;
	typedef logic [2:0]   chan_count_t;
	typedef logic [4:0]   err_index_t;
	typedef logic [127:0] header_log_t;

endpackage

/* File: header_log_capture.sv */
/*
 * sticky 128-bit header log with big-endian doubleword packing.
 * assumes header bytes arrive in wire order, byte k at bits 8k+7:8k,
 * and that sticky_rst_n is asserted only on power-up class resets.
 */
`timescale 1ns/10ps

module header_log_capture (
	input  wire logic                        core_clk,
	input  wire logic                        sticky_rst_n,
	input  wire logic                        capture,
	input  wire error_log_vc_pkg::header_log_t hdr_bytes,
	output error_log_vc_pkg::header_log_t    log_dw
);

	// ----------------------------------------------------------------
	// byte order
	// ----------------------------------------------------------------
	function automatic error_log_vc_pkg::header_log_t pack_big_endian(
		input error_log_vc_pkg::header_log_t b
	);
		error_log_vc_pkg::header_log_t r;
		r = '0;
		for (int d = 0; d < 4; d++) begin
			for (int k = 0; k < 4; k++) begin
				// first byte of each doubleword lands in the top lane
				r[32*d + 8*(3-k) +: 8] = b[32*d + 8*k +: 8];
			end
		end
		return r;
	endfunction

	error_log_vc_pkg::header_log_t log_reg;
	error_log_vc_pkg::header_log_t log_next;

	assign log_next = capture ? pack_big_endian(hdr_bytes) : log_reg;
	assign log_dw   = log_reg;

	always_ff @(posedge core_clk) begin
		if (!sticky_rst_n) begin
			log_reg <= '0;
		end else begin
			log_reg <= log_next;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_LOG_FIRST_LANE: assert property (@(posedge core_clk) disable iff (!sticky_rst_n)
		capture |=> log_dw[31:24] == $past(hdr_bytes[7:0]) && log_dw[7:0] == $past(hdr_bytes[31:24]))
		else $error("first header byte not in top lane");

	AST_LOG_FOURTH_DW: assert property (@(posedge core_clk) disable iff (!sticky_rst_n)
		capture |=> log_dw[127:120] == $past(hdr_bytes[103:96]) && log_dw[103:96] == $past(hdr_bytes[127:120]))
		else $error("fourth doubleword not at bits 127:96");

endmodule

/* File: error_log_vc_regs.sv */
/*
 * error capability/control, sticky header log and channel capability
 * registers of one switch port, reached by configuration accesses.
 * assumes the error status logic drives single-cycle event vectors on
 * core_clk and reports when the first error pointer may be re-armed.
 */
`timescale 1ns/10ps

`include "error_log_vc_defines.svh"

module error_log_vc_regs #(
	parameter int UNCOR_BITS = 32,
	parameter int COR_BITS   = 32
) (
	input  wire logic                             core_clk,
	input  wire logic                             rst_n,
	input  wire logic                             sticky_rst_n,
	input  wire logic                             cfg_req,
	input  wire logic                             cfg_we,
	input  wire error_log_vc_pkg::cfg_addr_t      cfg_addr,
	input  wire logic [3:0]                       cfg_be,
	input  wire error_log_vc_pkg::cfg_word_t      cfg_wdata,
	output logic                                  cfg_ack,
	output logic                                  cfg_hit,
	output error_log_vc_pkg::cfg_word_t           cfg_rdata,
	input  wire logic [UNCOR_BITS-1:0]            uncor_err_event,
	input  wire logic [COR_BITS-1:0]              cor_err_event,
	input  wire logic [COR_BITS-1:0]              cor_err_mask,
	input  wire logic                             log_rearm,
	input  wire error_log_vc_pkg::header_log_t    hdr_bytes,
	input  wire logic                             extra_channel_strap,
	input  wire logic                             eeprom_load,
	input  wire error_log_vc_pkg::chan_count_t    eeprom_ext_count,
	input  wire error_log_vc_pkg::chan_count_t    eeprom_lp_count,
	output logic                                  ecrc_gen_en,
	output logic                                  ecrc_chk_en,
	output error_log_vc_pkg::chan_count_t         ext_channel_count,
	output error_log_vc_pkg::chan_count_t         low_priority_channel_group
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (UNCOR_BITS < 1 || UNCOR_BITS > 32) begin : g_bad_uncor
		$error("UNCOR_BITS must lie in 1..32 for a 5-bit pointer");
	end
	if (COR_BITS < 1) begin : g_bad_cor
		$error("COR_BITS must be at least 1");
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic error_log_vc_pkg::err_index_t lowest_set(
		input logic [UNCOR_BITS-1:0] v
	);
		error_log_vc_pkg::err_index_t idx;
		idx = `RST_FIRST_ERROR_PTR;
		for (int i = UNCOR_BITS - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = i[4:0];
			end
		end
		return idx;
	endfunction

	function automatic logic is_addr(
		input error_log_vc_pkg::cfg_addr_t a,
		input error_log_vc_pkg::cfg_addr_t ofs
	);
		return a == ofs;
	endfunction

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	wire logic sel_ctl;
	wire logic sel_log0;
	wire logic sel_log1;
	wire logic sel_log2;
	wire logic sel_log3;
	wire logic sel_hdr;
	wire logic sel_cap1;
	wire logic sel_cap2;
	wire logic sel_any;
	wire logic wr_ctl;

	assign sel_ctl  = is_addr(cfg_addr, `OFS_ADV_ERR_CAP_CONTROL);
	assign sel_log0 = is_addr(cfg_addr, `OFS_ERROR_HEADER_LOG0);
	assign sel_log1 = is_addr(cfg_addr, `OFS_ERROR_HEADER_LOG1);
	assign sel_log2 = is_addr(cfg_addr, `OFS_ERROR_HEADER_LOG2);
	assign sel_log3 = is_addr(cfg_addr, `OFS_ERROR_HEADER_LOG3);
	assign sel_hdr  = is_addr(cfg_addr, `OFS_CHANNEL_EXT_CAP_HEADER);
	assign sel_cap1 = is_addr(cfg_addr, `OFS_PORT_CHANNEL_CAP_ONE);
	assign sel_cap2 = is_addr(cfg_addr, `OFS_PORT_CHANNEL_CAP_TWO);
	assign sel_any  = sel_ctl | sel_log0 | sel_log1 | sel_log2 | sel_log3 | sel_hdr | sel_cap1 | sel_cap2;
	// only the control word has writable bits; every other write is dropped
	assign wr_ctl   = cfg_req & cfg_we & sel_ctl;

	// ----------------------------------------------------------------
	// first error pointer and log arming (sticky)
	// ----------------------------------------------------------------
	error_log_vc_pkg::err_index_t first_ptr_reg;
	error_log_vc_pkg::err_index_t first_ptr_next;
	logic                         armed_reg;
	logic                         armed_next;
	wire logic                    uncor_hit;
	wire logic                    cor_loggable;
	wire logic                    log_capture;
	wire error_log_vc_pkg::err_index_t first_idx;

	assign uncor_hit    = |uncor_err_event;
	assign cor_loggable = |(cor_err_event & ~cor_err_mask);
	assign log_capture  = armed_reg & (uncor_hit | cor_loggable);
	assign first_idx    = lowest_set(uncor_err_event);
	assign first_ptr_next = (armed_reg & uncor_hit) ? first_idx : first_ptr_reg;
	// a capture beats a re-arm in the same cycle and keeps the log locked; an event in a re-arm cycle while locked is not logged
	assign armed_next   = log_capture ? 1'b0 : (log_rearm ? 1'b1 : armed_reg);

	always_ff @(posedge core_clk) begin
		if (!sticky_rst_n) begin
			first_ptr_reg <= `RST_FIRST_ERROR_PTR;
			armed_reg     <= 1'b1;
		end else begin
			first_ptr_reg <= first_ptr_next;
			armed_reg     <= armed_next;
		end
	end

	error_log_vc_pkg::header_log_t log_dw;

	header_log_capture u_log (
		.core_clk     (core_clk),
		.sticky_rst_n (sticky_rst_n),
		.capture      (log_capture),
		.hdr_bytes    (hdr_bytes),
		.log_dw       (log_dw)
	);

	// ----------------------------------------------------------------
	// end-to-end CRC enables (sticky read-write)
	// ----------------------------------------------------------------
	logic      gen_en_reg;
	logic      chk_en_reg;
	wire logic gen_en_next;
	wire logic chk_en_next;

	assign gen_en_next = (wr_ctl & cfg_be[0]) ? cfg_wdata[`BIT_CRC_GEN_ENABLE] : gen_en_reg;
	assign chk_en_next = (wr_ctl & cfg_be[1]) ? cfg_wdata[`BIT_CRC_CHK_ENABLE] : chk_en_reg;

	always_ff @(posedge core_clk) begin
		if (!sticky_rst_n) begin
			gen_en_reg <= `RST_CRC_GEN_ENABLE;
			chk_en_reg <= `RST_CRC_CHK_ENABLE;
		end else if (rst_n) begin
			gen_en_reg <= gen_en_next;
			chk_en_reg <= chk_en_next;
		end
	end

	assign ecrc_gen_en = gen_en_reg;
	assign ecrc_chk_en = chk_en_reg;

	// ----------------------------------------------------------------
	// channel counts: strap, then EEPROM auto-load
	// ----------------------------------------------------------------
	logic                          strap_meta_reg;
	logic                          strap_sync_reg;
	logic                          strap_done_reg;
	error_log_vc_pkg::chan_count_t ext_count_reg;
	error_log_vc_pkg::chan_count_t ext_count_next;
	error_log_vc_pkg::chan_count_t lp_count_reg;
	error_log_vc_pkg::chan_count_t lp_count_next;

	always_ff @(posedge core_clk) begin
		strap_meta_reg <= extra_channel_strap;
		strap_sync_reg <= strap_meta_reg;
	end

	// EEPROM wins over a strap capture in the same cycle
	assign ext_count_next = eeprom_load ? eeprom_ext_count :
		(!strap_done_reg ? {`RST_EXT_COUNT_HI, strap_sync_reg} : ext_count_reg);
	assign lp_count_next  = eeprom_load ? eeprom_lp_count : lp_count_reg;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			strap_done_reg <= 1'b0;
			ext_count_reg  <= `RST_EXT_COUNT;
			lp_count_reg   <= `RST_LOW_PRIO_COUNT;
		end else begin
			strap_done_reg <= 1'b1;
			ext_count_reg  <= ext_count_next;
			lp_count_reg   <= lp_count_next;
		end
	end

	assign ext_channel_count          = ext_count_reg;
	assign low_priority_channel_group = lp_count_reg;

	// ----------------------------------------------------------------
	// read words
	// ----------------------------------------------------------------
	wire error_log_vc_pkg::cfg_word_t word_ctl;
	wire error_log_vc_pkg::cfg_word_t word_hdr;
	wire error_log_vc_pkg::cfg_word_t word_cap1;
	wire error_log_vc_pkg::cfg_word_t word_cap2;
	wire logic [7:0]                  arb_cap;
	wire logic [7:0]                  table_ofs;
	wire error_log_vc_pkg::cfg_word_t rd_word;

	assign word_ctl = {23'h000000,
		chk_en_reg,
		`VAL_CRC_CHK_CAPABLE,
		gen_en_reg,
		`VAL_CRC_GEN_CAPABLE,
		first_ptr_reg};
	assign word_hdr = {`VAL_NEXT_CAP_OFFSET,
		`VAL_CAP_VERSION,
		`VAL_EXT_CAP_ID};
	assign word_cap1 = {20'h00000,
		`VAL_ENTRY_SIZE_4BIT,
		`VAL_REF_CLOCK_100NS,
		1'h0,
		lp_count_reg,
		1'h0,
		ext_count_reg};
	// nonzero only while bit 0 of the extended channel count is one; the low-priority group count plays no part
	assign arb_cap   = ext_count_reg[0] ? `VAL_ARB_CAP_ON : `VAL_ARB_CAP_OFF;
	assign table_ofs = ext_count_reg[0] ? `VAL_TABLE_OFS_ON : `VAL_TABLE_OFS_OFF;
	assign word_cap2 = {table_ofs, 16'h0000, arb_cap};

	assign rd_word = sel_ctl  ? word_ctl      :
	                 sel_log0 ? log_dw[31:0]  :
	                 sel_log1 ? log_dw[63:32] :
	                 sel_log2 ? log_dw[95:64] :
	                 sel_log3 ? log_dw[127:96] :
	                 sel_hdr  ? word_hdr      :
	                 sel_cap1 ? word_cap1     :
	                 sel_cap2 ? word_cap2     : 32'h00000000;

	// ----------------------------------------------------------------
	// answer path
	// ----------------------------------------------------------------
	logic                        ack_reg;
	logic                        hit_reg;
	error_log_vc_pkg::cfg_word_t rdata_reg;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ack_reg   <= 1'b0;
			hit_reg   <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			ack_reg   <= cfg_req;
			hit_reg   <= cfg_req & sel_any;
			// writes answer with zero data so stale reads never leak out
			rdata_reg <= (cfg_req & ~cfg_we) ? rd_word : 32'h00000000;
		end
	end

	assign cfg_ack   = ack_reg;
	assign cfg_hit   = hit_reg;
	assign cfg_rdata = rdata_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	wire logic rd_req;

	assign rd_req = cfg_req & ~cfg_we;

	AST_FIRST_PTR: assert property (@(posedge core_clk) disable iff (!sticky_rst_n)
		armed_reg && uncor_hit |=> first_ptr_reg == $past(first_idx) && !armed_reg)
		else $error("first error pointer not captured");

	AST_PTR_HOLD: assert property (@(posedge core_clk) disable iff (!sticky_rst_n)
		!armed_reg |=> $stable(first_ptr_reg))
		else $error("first error pointer moved while locked");

	AST_GEN_CAPABLE: assert property (@(posedge core_clk) disable iff (!rst_n || !sticky_rst_n)
		rd_req && sel_ctl |=> cfg_rdata[`BIT_CRC_GEN_CAPABLE] && cfg_ack)
		else $error("generation capable bit not one");

	AST_GEN_ENABLE: assert property (@(posedge core_clk) disable iff (!rst_n || !sticky_rst_n)
		wr_ctl && cfg_be[0] |=> ecrc_gen_en == $past(cfg_wdata[`BIT_CRC_GEN_ENABLE]))
		else $error("generation enable not written");

	AST_CHK_CAPABLE: assert property (@(posedge core_clk) disable iff (!rst_n || !sticky_rst_n)
		rd_req && sel_ctl |=> cfg_rdata[`BIT_CRC_CHK_CAPABLE] && cfg_rdata[31:9] == 23'h000000)
		else $error("check capable bit or reserved bits wrong");

	AST_CHK_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n || !sticky_rst_n)
		!(wr_ctl && cfg_be[1]) |=> $stable(ecrc_chk_en))
		else $error("check enable changed without a write");

	AST_CAP_HEADER: assert property (@(posedge core_clk) disable iff (!rst_n)
		rd_req && sel_hdr |=> cfg_rdata[19:0] == {`VAL_CAP_VERSION, `VAL_EXT_CAP_ID})
		else $error("capability identifier or version wrong");

	AST_NEXT_POINTER: assert property (@(posedge core_clk) disable iff (!rst_n)
		rd_req && sel_hdr |=> cfg_rdata[31:20] == `VAL_NEXT_CAP_OFFSET && cfg_hit)
		else $error("next capability pointer wrong");

	AST_STRAP_COUNT: assert property (@(posedge core_clk) disable iff (!rst_n)
		!strap_done_reg && !eeprom_load |=> ext_count_reg == {`RST_EXT_COUNT_HI, $past(strap_sync_reg)})
		else $error("strap not taken into channel count");

	AST_ARB_FOLLOWS: assert property (@(posedge core_clk) disable iff (!rst_n)
		rd_req && sel_cap2 |=> cfg_rdata[7:0] == ($past(ext_count_reg[0]) ? `VAL_ARB_CAP_ON : `VAL_ARB_CAP_OFF)
		&& cfg_rdata[31:24] == ($past(ext_count_reg[0]) ? `VAL_TABLE_OFS_ON : `VAL_TABLE_OFS_OFF))
		else $error("arbitration capability or table offset wrong");

	AST_MASKED_NO_LOG: assert property (@(posedge core_clk) disable iff (!sticky_rst_n)
		!uncor_hit && !cor_loggable |=> $stable(log_dw))
		else $error("header log changed on a masked event");

	AST_UNMAPPED_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
		cfg_req && !sel_any |=> cfg_rdata == 32'h00000000 && !cfg_hit && cfg_ack)
		else $error("unmapped access not answered with zero");

	COV_PTR_CAPTURE: cover property (@(posedge core_clk) disable iff (!sticky_rst_n)
		armed_reg && uncor_hit);
	COV_MASKED_EVENT: cover property (@(posedge core_clk) disable iff (!sticky_rst_n)
		armed_reg && (|cor_err_event) && !cor_loggable && !uncor_hit);
	COV_EEPROM_LOAD: cover property (@(posedge core_clk) disable iff (!rst_n)
		eeprom_load ##1 ext_count_reg[0]);
	COV_BOTH_ENABLES: cover property (@(posedge core_clk) disable iff (!rst_n || !sticky_rst_n)
		ecrc_gen_en && ecrc_chk_en);

endmodule

/* File: error_log_vc_regs_tb.sv */
/*
 * self-checking bench for the error log and channel capability bank.
 * assumes the top module error_log_vc_regs with its default widths.
 */
`timescale 1ns/10ps

`include "error_log_vc_defines.svh"

`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin failures++; \
	$display("wrong value %s expected %h seen %h", what, exp, got); end end

module error_log_and_vc_capability_regs_test;
	logic                           core_clk, rst_n, sticky_rst_n, cfg_req, cfg_we, cfg_ack, cfg_hit;
	error_log_vc_pkg::cfg_addr_t    cfg_addr;
	logic [3:0]                     cfg_be;
	error_log_vc_pkg::cfg_word_t    cfg_wdata, cfg_rdata;
	logic [31:0]                    uncor_err_event, cor_err_event, cor_err_mask;
	logic                           log_rearm, extra_channel_strap, eeprom_load, ecrc_gen_en, ecrc_chk_en;
	error_log_vc_pkg::header_log_t  hdr_bytes, logv, hv;
	error_log_vc_pkg::chan_count_t  eeprom_ext_count, eeprom_lp_count, ext_channel_count, low_priority_channel_group;
	error_log_vc_pkg::chan_count_t  ext, lp;
	error_log_vc_pkg::err_index_t   ptr;
	logic                           gen, chk, armed;
	error_log_vc_pkg::cfg_word_t    wd;
	logic [3:0]                     be;
	int                             seed = 61;
	int                             failures = 0;
	int                             checks = 0;

	error_log_vc_regs error_log_vc_regs_i (.core_clk(core_clk), .rst_n(rst_n), .sticky_rst_n(sticky_rst_n),
		.cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
		.cfg_ack(cfg_ack), .cfg_hit(cfg_hit), .cfg_rdata(cfg_rdata), .uncor_err_event(uncor_err_event),
		.cor_err_event(cor_err_event), .cor_err_mask(cor_err_mask), .log_rearm(log_rearm),
		.hdr_bytes(hdr_bytes), .extra_channel_strap(extra_channel_strap), .eeprom_load(eeprom_load),
		.eeprom_ext_count(eeprom_ext_count), .eeprom_lp_count(eeprom_lp_count), .ecrc_gen_en(ecrc_gen_en),
		.ecrc_chk_en(ecrc_chk_en), .ext_channel_count(ext_channel_count),
		.low_priority_channel_group(low_priority_channel_group));

	// ----------------------------------------------------------------
	// clock, watchdog and verdict
	// ----------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		wrap_up;
	end

	// ----------------------------------------------------------------
	// expectations and bus cycles
	// ----------------------------------------------------------------
	// first header byte lands in the top lane of each dword
	function automatic error_log_vc_pkg::cfg_word_t dw(input error_log_vc_pkg::header_log_t h, input int d);
		return {h[32*d+:8], h[32*d+8+:8], h[32*d+16+:8], h[32*d+24+:8]};
	endfunction

	task automatic access(input logic we, input error_log_vc_pkg::cfg_addr_t a, input logic [3:0] b,
		input error_log_vc_pkg::cfg_word_t w, input error_log_vc_pkg::cfg_word_t exp, input logic exp_hit);
		int n;
		@(posedge core_clk);
		cfg_req <= 1'b1;
		cfg_we <= we;
		cfg_addr <= a;
		cfg_be <= b;
		cfg_wdata <= w;
		@(posedge core_clk);
		cfg_req <= 1'b0;
		#1;
		for (n = 0; n < 4 && cfg_ack !== 1'b1; n++) begin
			@(posedge core_clk);
			#1;
		end
		if (n != 0) begin
			failures++;
			wrap_up;
		end
		`CHK("cfg_rdata", exp, cfg_rdata)
		`CHK("cfg_hit", exp_hit, cfg_hit)
	endtask

	task automatic rd(input error_log_vc_pkg::cfg_addr_t a, input error_log_vc_pkg::cfg_word_t exp);
		access(1'b0, a, 4'hF, $random(seed), exp, 1'b1);
	endtask

	task automatic check_log;
		rd(`OFS_ADV_ERR_CAP_CONTROL, {23'h0, chk, 1'b1, gen, 1'b1, ptr});
		for (int d = 0; d < 4; d++) rd(`OFS_ERROR_HEADER_LOG0 + 12'(4 * d), dw(logv, d));
		`CHK("ecrc_gen_en", gen, ecrc_gen_en)
		`CHK("ecrc_chk_en", chk, ecrc_chk_en)
	endtask

	task automatic check_vc;
		rd(`OFS_CHANNEL_EXT_CAP_HEADER, 32'h20C10002);
		rd(`OFS_PORT_CHANNEL_CAP_ONE, {20'h0, 2'h2, 2'h0, 1'b0, lp, 1'b0, ext});
		// software reads the capability whatever the extended channel count; bit 0 of that count decides the expected value
		rd(`OFS_PORT_CHANNEL_CAP_TWO, ext[0] ? 32'h03000003 : 32'h00000000);
		`CHK("ext_channel_count", ext, ext_channel_count)
		`CHK("low_priority_channel_group", lp, low_priority_channel_group)
	endtask

	task automatic do_reset(input logic sticky, input logic strap);
		@(posedge core_clk);
		rst_n <= 1'b0;
		sticky_rst_n <= ~sticky;
		extra_channel_strap <= strap;
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		sticky_rst_n <= 1'b1;
		ext = {2'h0, strap};
		lp = 3'h0;
		if (sticky) begin
			{gen, chk, ptr, logv, armed} = {2'b00, 5'h00, 128'h0, 1'b1};
		end
	endtask

	// one event cycle; capture beats a re-arm in the same cycle
	task automatic ev(input logic [31:0] u, input logic [31:0] c, input logic [31:0] m, input logic rr);
		logic cap;
		hv = {$random(seed), $random(seed), $random(seed), $random(seed)};
		@(posedge core_clk);
		{uncor_err_event, cor_err_event, cor_err_mask, log_rearm, hdr_bytes} <= {u, c, m, rr, hv};
		@(posedge core_clk);
		{uncor_err_event, cor_err_event, log_rearm} <= '0;
		cap = armed && (u != 0 || (c & ~m) != 0);
		if (cap) logv = hv;
		if (cap && u != 0) for (int i = 31; i >= 0; i--) if (u[i]) ptr = 5'(i);
		armed = cap ? 1'b0 : (armed | rr);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		{rst_n, sticky_rst_n, cfg_req, cfg_we, cfg_addr, cfg_be, cfg_wdata} = '0;
		{uncor_err_event, cor_err_event, cor_err_mask, log_rearm, hdr_bytes} = '0;
		{extra_channel_strap, eeprom_load, eeprom_ext_count, eeprom_lp_count} = '0;
		do_reset(1'b1, 1'b1);
		check_vc;
		check_log;
		access(1'b0, 12'h14C, 4'hF, 32'h0, 32'h0, 1'b0);
		access(1'b0, 12'h12C, 4'hF, 32'h0, 32'h0, 1'b0);
		$display("test reset values done");
		for (int k = 0; k < 12; k++) begin
			wd = (k == 0) ? 32'hFFFFFFFF : $random(seed);
			be = (k == 0) ? 4'hF : 4'($random(seed));
			if (be[0]) gen = wd[6];
			if (be[1]) chk = wd[8];
			access(1'b1, `OFS_ADV_ERR_CAP_CONTROL, be, wd, 32'h0, 1'b1);
			check_log;
		end
		for (int k = 0; k < 4; k++) begin
			// the fourth slot lies past the bank and must not hit
			access(1'b1, `OFS_CHANNEL_EXT_CAP_HEADER + 12'(4 * k), 4'hF, 32'hFFFFFFFF, 32'h0, k < 3);
		end
		check_vc;
		$display("test enable writes done");
		gen = 1'b1;
		chk = 1'b1;
		access(1'b1, `OFS_ADV_ERR_CAP_CONTROL, 4'h3, 32'h00000140, 32'h0, 1'b1);
		do_reset(1'b0, 1'b0);
		check_vc;
		check_log;
		for (int k = 0; k < 6; k++) begin
			@(posedge core_clk);
			ext = 3'($random(seed));
			lp = 3'($random(seed));
			{eeprom_load, eeprom_ext_count, eeprom_lp_count} <= {1'b1, ext, lp};
			@(posedge core_clk);
			eeprom_load <= 1'b0;
			check_vc;
		end
		$display("test strap and eeprom done");
		ev(32'h0, 32'h00000041, 32'h00000041, 1'b0);
		check_log;
		ev(32'h1 << ($unsigned($random(seed)) % 32), 32'h0, 32'h0, 1'b0);
		check_log;
		ev(32'h00000018, 32'h1, 32'h0, 1'b1);
		check_log;
		ev(32'h0, 32'h0, 32'h0, 1'b1);
		ev(32'h0, 32'h00001000, 32'h00000001, 1'b0);
		check_log;
		ev(32'h0, 32'h0, 32'h0, 1'b1);
		ev(32'h00000018, 32'h0, 32'h0, 1'b0);
		check_log;
		do_reset(1'b0, 1'b1);
		check_log;
		do_reset(1'b1, 1'b1);
		check_log;
		$display("test error log done");
		wrap_up;
	end
endmodule
